// [dmac_partner.sv]
// Purpose: preceding slice feeding both cascade buses
// Assumes: values held steady by the bench
// Notes: buses come from registers, as a real neighbour's would
`timescale 1ns/1ps
`default_nettype none
module dmac_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [18:0] casc_val,
  input  wire logic [63:0] psum_val,
  output logic      [18:0] casc_drv,
  output logic      [63:0] psum_drv
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      casc_drv <= 19'h00000;
      psum_drv <= 64'h0;
    end
    else
    begin
      casc_drv <= casc_val;
      psum_drv <= psum_val;
    end
endmodule : dmac_partner
`default_nettype wire

// [dmac_pkg.sv]
// Purpose: constants for the dual multiply-add cascade slice
// Assumes: pclk at 200 MHz, APB slave with 32-bit data
// Notes: Function list below gives the behaviour in short
//
// Function
// RL1 - chain-output block 0 forwards result on partial-sum out; 1 drives zeros
// RL2 - integrator wires partial-sum out to the next slice for blocking to matter
// RL3 - bypass 0 takes top y from cascade in; 1 takes top y port
// RL4 - bypass control honoured only when option and top y cascading are both on
// RL5 - accumulate 0 gives current result; 1 adds the previously held result
// RL6 - bias preload 1 adds the preload constant; 0 adds nothing
// RL7 - pair subtract 0 sums products; 1 gives bottom minus top product
// RL8 - chain subtract 1 subtracts product sum from chain input plus feedback
// RL9 - all six dynamic controls may change every cycle while running
// RL10 - 3-bit top index picks one of 8 stored top coefficients, 000 first
// RL11 - 3-bit bottom index picks bottom coefficient, 001 second entry
// RL12 - with coefficient store on, top x port is ignored, store supplies it
// RL13 - 19-bit cascade operand input comes from the preceding slice
// RL14 - 19-bit cascade operand output goes to the next slice
// RL15 - 64-bit partial-sum input fed from the preceding slice
// RL16 - 64-bit partial-sum output routed to the next slice
// RL17 - one clock, three active-high enables gate all registers
// RL18 - two active-high clears, async or sync by parameter, idle low
// RL19 - pre-adder sums top y and 18-bit top pre-add operand when enabled
// RL20 - multipliers take 18-bit x and 19-bit y; bottom from own ports
// RL21 - dynamic controls registered with operands, same enable and clear

package dmac_pkg;
  localparam int X_W    = 18;
  localparam int Y_W    = 19;
  localparam int Z_W    = 18;
  localparam int PA_W   = 20;
  localparam int PT_W   = 38;
  localparam int PS_W   = 39;
  localparam int R_W    = 64;
  localparam int EN_W   = 3;
  localparam int CLR_W  = 2;
  localparam int SEL_W  = 3;
  localparam int NCOEF  = 8;
  localparam int ADDR_W = 12;
  // enable and clear lanes
  localparam int EN_IN  = 0;
  localparam int EN_PIP = 1;
  localparam int EN_OUT = 2;
  localparam int CLR_IN = 0;
  localparam int CLR_OUT = 1;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONST_LO = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CONST_HI = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_RES_LO   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_RES_HI   = 12'h00C;
  localparam logic [R_W-1:0]    CONST_RST    = 64'h0000_0000_0000_0000;
  localparam logic [31:0]       RDATA_NONE   = 32'h0000_0000;
endpackage : dmac_pkg

// [dmac_slice.sv]
// Purpose: dual 18x19 multiply-add slice with operand and sum cascades
// Assumes: all inputs synchronous to pclk; APB master keeps to protocol
// Notes: optional ports exist always and are ignored when disabled
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dmac_slice #(
  parameter bit PREADD_EN = 1'b0,
  parameter bit COEF_EN   = 1'b0,
  parameter bit CASC_EN   = 1'b0,
  parameter bit BYPASS_EN = 1'b0,
  parameter bit CLR_ASYNC = 1'b0,
  parameter logic [dmac_pkg::X_W-1:0] COEF_A [dmac_pkg::NCOEF] =
    '{default: 18'h00000},
  parameter logic [dmac_pkg::X_W-1:0] COEF_B [dmac_pkg::NCOEF] =
    '{default: 18'h00000}
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [dmac_pkg::EN_W-1:0]   ena,
  input  wire logic [dmac_pkg::CLR_W-1:0]  clr,
  input  wire logic [dmac_pkg::X_W-1:0]    top_x_operand,
  input  wire logic [dmac_pkg::Y_W-1:0]    top_y_operand,
  input  wire logic [dmac_pkg::Z_W-1:0]    top_preadd_operand,
  input  wire logic [dmac_pkg::X_W-1:0]    bottom_x_operand,
  input  wire logic [dmac_pkg::Y_W-1:0]    bottom_y_operand,
  input  wire logic [dmac_pkg::SEL_W-1:0]  top_coef_sel,
  input  wire logic [dmac_pkg::SEL_W-1:0]  bottom_coef_sel,
  input  wire logic                        chain_block,
  input  wire logic                        casc_bypass,
  input  wire logic                        accumulate,
  input  wire logic                        bias_preload,
  input  wire logic                        pair_sub,
  input  wire logic                        chain_sub,
  input  wire logic [dmac_pkg::Y_W-1:0]    casc_in,
  output logic      [dmac_pkg::Y_W-1:0]    casc_out,
  input  wire logic [dmac_pkg::R_W-1:0]    psum_in,
  output logic      [dmac_pkg::R_W-1:0]    psum_out,
  output logic      [dmac_pkg::R_W-1:0]    result,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dmac_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr
);

  // clears folded into the async reset only when configured so
  logic arst_in_n;
  logic arst_out_n;
  logic sclr_in;
  logic sclr_out;
  assign arst_in_n  = presetn & ~(CLR_ASYNC & clr[dmac_pkg::CLR_IN]);  // [RL18]
  assign arst_out_n = presetn & ~(CLR_ASYNC & clr[dmac_pkg::CLR_OUT]); // [RL18]
  assign sclr_in    = ~CLR_ASYNC & clr[dmac_pkg::CLR_IN];              // [RL18]
  assign sclr_out   = ~CLR_ASYNC & clr[dmac_pkg::CLR_OUT];             // [RL18]

  // input stage
  logic [dmac_pkg::X_W-1:0] tx_reg;
  logic [dmac_pkg::Y_W-1:0] ty_reg;
  logic [dmac_pkg::Z_W-1:0] tz_reg;
  logic [dmac_pkg::X_W-1:0] bx_reg;
  logic [dmac_pkg::Y_W-1:0] by_reg;
  // controls travel with their operands; bypass acts ahead of the input flops, pair subtract stops at the first stage
  logic                     blk1_reg;
  logic                     acc1_reg;
  logic                     bias1_reg;
  logic                     psub1_reg;
  logic                     csub1_reg;
  logic [dmac_pkg::X_W-1:0] tx_next;
  logic [dmac_pkg::Y_W-1:0] ty_next;
  logic [dmac_pkg::X_W-1:0] bx_next;
  logic                     use_casc;

  // bypass is only meaningful with cascading and its option both on
  assign use_casc = CASC_EN & ~(BYPASS_EN & casc_bypass);        // [RL3] [RL4]
  assign ty_next  = use_casc ? casc_in : top_y_operand;          // [RL3] [RL13]
  assign tx_next  = COEF_EN ? COEF_A[top_coef_sel]
                            : top_x_operand;                     // [RL10] [RL12]
  assign bx_next  = COEF_EN ? COEF_B[bottom_coef_sel]
                            : bottom_x_operand;                  // [RL11] [RL20]

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      tx_reg <= '0;
    else if (sclr_in)
      tx_reg <= '0;
    else if (ena[dmac_pkg::EN_IN])                               // [RL17]
      tx_reg <= tx_next;
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      ty_reg <= '0;
    else if (sclr_in)
      ty_reg <= '0;
    else if (ena[dmac_pkg::EN_IN])                               // [RL17]
      ty_reg <= ty_next;
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      tz_reg <= '0;
    else if (sclr_in)
      tz_reg <= '0;
    else if (ena[dmac_pkg::EN_IN])                               // [RL17]
      tz_reg <= top_preadd_operand;                              // [RL19]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      bx_reg <= '0;
    else if (sclr_in)
      bx_reg <= '0;
    else if (ena[dmac_pkg::EN_IN])                               // [RL17]
      bx_reg <= bx_next;
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      by_reg <= '0;
    else if (sclr_in)
      by_reg <= '0;
    else if (ena[dmac_pkg::EN_IN])                               // [RL17]
      by_reg <= bottom_y_operand;                                // [RL20]
  end

  // controls sampled with their operands, free to change each cycle;
  // a control changed mid-stream only affects the operands beside it
  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      blk1_reg <= 1'b0;
    else if (sclr_in)
      blk1_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_IN])
      blk1_reg <= chain_block;                                   // [RL9] [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      acc1_reg <= 1'b0;
    else if (sclr_in)
      acc1_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_IN])
      acc1_reg <= accumulate;                                    // [RL9] [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      bias1_reg <= 1'b0;
    else if (sclr_in)
      bias1_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_IN])
      bias1_reg <= bias_preload;                                 // [RL9] [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      psub1_reg <= 1'b0;
    else if (sclr_in)
      psub1_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_IN])
      psub1_reg <= pair_sub;                                     // [RL9] [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      csub1_reg <= 1'b0;
    else if (sclr_in)
      csub1_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_IN])
      csub1_reg <= chain_sub;                                    // [RL9] [RL21]
  end

  // cascade operand follows the registered top y
  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      casc_out <= '0;
    else if (sclr_in)
      casc_out <= '0;
    else if (ena[dmac_pkg::EN_IN])
      casc_out <= ty_next;                                       // [RL14]
  end

  // pre-adder and multipliers
  logic signed [dmac_pkg::PA_W-1:0] ty_eff;
  logic signed [dmac_pkg::PT_W-1:0] prod_top;
  logic signed [dmac_pkg::PT_W-1:0] prod_bot;
  logic signed [dmac_pkg::PS_W-1:0] pair_sum;

  assign ty_eff = PREADD_EN
    ? dmac_pkg::PA_W'($signed(ty_reg) + $signed(tz_reg))         // [RL19]
    : dmac_pkg::PA_W'($signed(ty_reg));
  assign prod_top = dmac_pkg::PT_W'($signed(tx_reg) * ty_eff);   // [RL20]
  assign prod_bot = dmac_pkg::PT_W'($signed(bx_reg) * $signed(by_reg));
  assign pair_sum = psub1_reg
    ? dmac_pkg::PS_W'(prod_bot - prod_top)                       // [RL7]
    : dmac_pkg::PS_W'(prod_bot + prod_top);                      // [RL7]

  // pipeline stage
  logic [dmac_pkg::PS_W-1:0] sum_reg;
  logic                      blk2_reg;
  logic                      acc2_reg;
  logic                      bias2_reg;
  logic                      csub2_reg;

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      sum_reg <= '0;
    else if (sclr_in)
      sum_reg <= '0;
    else if (ena[dmac_pkg::EN_PIP])                              // [RL17]
      sum_reg <= pair_sum;
  end

  // pair subtract is spent at this stage, the other controls move on
  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      blk2_reg <= 1'b0;
    else if (sclr_in)
      blk2_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_PIP])
      blk2_reg <= blk1_reg;                                      // [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      acc2_reg <= 1'b0;
    else if (sclr_in)
      acc2_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_PIP])
      acc2_reg <= acc1_reg;                                      // [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      bias2_reg <= 1'b0;
    else if (sclr_in)
      bias2_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_PIP])
      bias2_reg <= bias1_reg;                                    // [RL21]
  end

  always_ff @(posedge pclk or negedge arst_in_n)
  begin
    if (!arst_in_n)
      csub2_reg <= 1'b0;
    else if (sclr_in)
      csub2_reg <= 1'b0;
    else if (ena[dmac_pkg::EN_PIP])
      csub2_reg <= csub1_reg;                                    // [RL21]
  end

  // chain adder with accumulator feedback and preload
  logic [dmac_pkg::R_W-1:0] const_reg;
  logic [dmac_pkg::R_W-1:0] sum_ext;
  logic [dmac_pkg::R_W-1:0] feed;
  logic [dmac_pkg::R_W-1:0] base;
  logic [dmac_pkg::R_W-1:0] res_next;

  assign sum_ext = dmac_pkg::R_W'($signed(sum_reg));
  assign feed    = acc2_reg ? result : '0;                       // [RL5]
  assign base    = psum_in + feed
                 + (bias2_reg ? const_reg : '0);                 // [RL6] [RL15]
  assign res_next = csub2_reg ? base - sum_ext                   // [RL8]
                              : base + sum_ext;                  // [RL8]

  always_ff @(posedge pclk or negedge arst_out_n)
  begin
    if (!arst_out_n)
      result <= '0;
    else if (sclr_out)
      result <= '0;
    else if (ena[dmac_pkg::EN_OUT])                              // [RL17]
      result <= res_next;
  end

  // blocking only zeroes the cascade, the local result still forms
  always_ff @(posedge pclk or negedge arst_out_n)
  begin
    if (!arst_out_n)
      psum_out <= '0;
    else if (sclr_out)
      psum_out <= '0;
    else if (ena[dmac_pkg::EN_OUT])                              // [RL17]
      psum_out <= blk2_reg ? '0 : res_next;                      // [RL1] [RL16]
  end

  // APB slave: one wait state, answer flagged by pready
  logic apb_acc;
  logic apb_done;
  logic hit;
  logic [31:0] rd_next;

  assign apb_acc  = psel & penable & ~pready;
  assign apb_done = psel & penable & pready;

  always_comb
  begin
    hit     = 1'b1;
    rd_next = dmac_pkg::RDATA_NONE;
    case (paddr)
      dmac_pkg::OFS_CONST_LO: rd_next = const_reg[31:0];
      dmac_pkg::OFS_CONST_HI: rd_next = const_reg[63:32];
      dmac_pkg::OFS_RES_LO:   rd_next = result[31:0];
      dmac_pkg::OFS_RES_HI:   rd_next = result[63:32];
      default:                hit     = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= dmac_pkg::RDATA_NONE;
    end
    else
    begin
      pready  <= apb_acc;
      // result words are read-only, writing them is an error
      pslverr <= apb_acc & (~hit | (pwrite &
                 (paddr == dmac_pkg::OFS_RES_LO ||
                  paddr == dmac_pkg::OFS_RES_HI)));
      prdata  <= (apb_acc & ~pwrite) ? rd_next : dmac_pkg::RDATA_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      const_reg <= dmac_pkg::CONST_RST;
    else if (apb_done & pwrite)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (pstrb[b] && paddr == dmac_pkg::OFS_CONST_LO)
          const_reg[8*b +: 8] <= pwdata[8*b +: 8];
        if (pstrb[b] && paddr == dmac_pkg::OFS_CONST_HI)
          const_reg[32+8*b +: 8] <= pwdata[8*b +: 8];
      end
    end
  end

endmodule : dmac_slice

`default_nettype wire

// [dmac_slice_sva.sv]
// Purpose: port checker for the multiply-add slice
// Assumes: instance built with cascade and bypass options on, sync clears
// Notes: pipe timing is only judged while every enable is high
`timescale 1ns/1ps
`default_nettype none
module dmac_slice_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [2:0]  ena,
  input wire logic [1:0]  clr,
  input wire logic [18:0] top_y_operand,
  input wire logic [18:0] casc_in,
  input wire logic        casc_bypass,
  input wire logic        chain_block,
  input wire logic [18:0] casc_out,
  input wire logic [63:0] psum_out,
  input wire logic [63:0] result,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_run;
    ena == 3'h7 && clr == 2'h0;
  endsequence
  property p_block;
    (s_run ##0 chain_block) ##1 s_run ##1 s_run |=> psum_out == 64'h0;
  endproperty
  property p_fwd;
    (s_run ##0 !chain_block) ##1 s_run ##1 s_run |=> psum_out == result;
  endproperty
  property p_bypass;
    ena[0] && !clr[0] && casc_bypass |=> casc_out == $past(top_y_operand);
  endproperty
  property p_cascin;
    ena[0] && !clr[0] && !casc_bypass |=> casc_out == $past(casc_in);
  endproperty
  property p_hold_out;
    !ena[2] && !clr[1] |=> $stable(result) && $stable(psum_out);
  endproperty
  property p_hold_in;
    !ena[0] && !clr[0] |=> $stable(casc_out);
  endproperty
  // sync clear wins over the enables
  property p_clr_out;
    clr[1] |=> result == 64'h0 && psum_out == 64'h0;
  endproperty
  property p_clr_in;
    clr[0] |=> casc_out == 19'h00000;
  endproperty
  property p_answer;
    psel && !penable ##1 psel && penable |=> pready;
  endproperty
  property p_pulse;
    pready |-> psel && penable ##1 !pready;
  endproperty
  a_block: assert property (p_block) else $error("psum_out not zero");
  a_fwd: assert property (p_fwd) else $error("psum_out not result");
  a_bypass: assert property (p_bypass) else $error("bypass y");
  a_cascin: assert property (p_cascin) else $error("cascade y");
  a_hold_out: assert property (p_hold_out) else $error("out moved");
  a_hold_in: assert property (p_hold_in) else $error("in moved");
  a_clr_out: assert property (p_clr_out) else $error("out clear");
  a_clr_in: assert property (p_clr_in) else $error("in clear");
  a_answer: assert property (p_answer) else $error("late pready");
  a_pulse: assert property (p_pulse) else $error("pready shape");
  c_block: cover property (s_run ##0 chain_block);
  c_bypass: cover property (ena[0] && casc_bypass);
  c_apb: cover property (pready);
endmodule : dmac_slice_sva
bind dmac_slice dmac_slice_sva u_sva (.pclk(pclk), .presetn(presetn),
  .ena(ena), .clr(clr), .top_y_operand(top_y_operand), .casc_in(casc_in),
  .casc_bypass(casc_bypass), .chain_block(chain_block),
  .casc_out(casc_out), .psum_out(psum_out), .result(result), .psel(psel),
  .penable(penable), .pready(pready));
`default_nettype wire

// [dmac_slice_test.sv]
// Purpose: directed bench for the multiply-add slice
// Assumes: coefficient store, cascade and bypass on; all enables high until the final clear and hold checks
// Notes: both x ports get junk, the store must hide it
`timescale 1ns/1ps
`default_nettype none
module dmac_slice_test;
  localparam logic [17:0] CA [8] = '{18'h00001, 18'h00002, 18'h00003,
    18'h00004, 18'h00005, 18'h00006, 18'h00007, 18'h00008};
  localparam logic [17:0] CB [8] = '{18'h00010, 18'h00020, 18'h00030,
    18'h00040, 18'h00050, 18'h00060, 18'h00070, 18'h00080};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [2:0]  ena = 3'h7;
  logic [1:0]  clr = 2'h0;
  logic [2:0]  tsel = 3'h0;
  logic [2:0]  bsel = 3'h0;
  logic [5:0]  ctl = 6'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] tx_op = 18'h3FFFF;
  logic [17:0] bx_op = 18'h2AAAA;
  logic [18:0] ty_op = 19'h00005;
  logic [18:0] by_op = 19'h00007;
  logic [18:0] cv = 19'h7FFFD;
  logic [63:0] pv = 64'h0000_0000_0000_1000;
  logic [3:0]  strb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, e;
  logic [18:0] casc_in, casc_out;
  logic [63:0] psum_in, psum_out, result, ev;
  int          fails = 0;
  int          checked = 0;
  dmac_slice #(.COEF_EN(1'b1), .CASC_EN(1'b1), .BYPASS_EN(1'b1),
    .COEF_A(CA), .COEF_B(CB)) dut (
    .pclk(pclk), .presetn(presetn), .ena(ena), .clr(clr),
    .top_x_operand(tx_op), .top_y_operand(ty_op),
    .top_preadd_operand(18'h00000), .bottom_x_operand(bx_op),
    .bottom_y_operand(by_op), .top_coef_sel(tsel),
    .bottom_coef_sel(bsel), .chain_block(ctl[5]), .casc_bypass(ctl[4]),
    .accumulate(ctl[3]), .bias_preload(ctl[2]), .pair_sub(ctl[1]),
    .chain_sub(ctl[0]), .casc_in(casc_in), .casc_out(casc_out),
    .psum_in(psum_in), .psum_out(psum_out), .result(result), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dmac_partner prev (.pclk(pclk), .presetn(presetn),
    .casc_val(cv), .psum_val(pv),
    .casc_drv(casc_in), .psum_drv(psum_in));
  initial forever #2.5 pclk = ~pclk;
  task automatic test_done();
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [63:0] x,
                     input logic [63:0] g);
    checked++;
    if (g !== x)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1)
    begin
      fails++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // top coefficient (i mod 8)+1 against bottom index 7-i, both y values signed
  function automatic logic [63:0] expect_of(input int i);
    longint ta, tb, ya, pr, b;
    ta = (i % 8) + 1;
    tb = 16 * (8 - (i % 8));
    ya = i[3] ? 5 : -3;
    pr = i[1] ? tb * 7 - ta * ya : tb * 7 + ta * ya;
    b = 64'h1000 + (i[2] ? 64'h0000_0001_0000_0100 : 64'h0);
    return i[0] ? b - pr : b + pr;
  endfunction : expect_of
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dmac_pkg::OFS_CONST_LO, 32'h0);
    chk("const_rst", 64'h0, {32'h0, q});
    apb(1'b1, dmac_pkg::OFS_CONST_LO, 32'h0000_0100);
    apb(1'b1, dmac_pkg::OFS_CONST_HI, 32'h0000_0001);
    strb <= 4'h0;
    apb(1'b1, dmac_pkg::OFS_CONST_LO, 32'hFFFF_FFFF);
    strb <= 4'hF;
    apb(1'b0, dmac_pkg::OFS_CONST_LO, 32'h0);
    chk("strb", 64'h100, {32'h0, q});
    apb(1'b1, dmac_pkg::OFS_RES_LO, 32'hFFFF_FFFF);
    chk("ro_err", 64'h1, {63'h0, e});
    apb(1'b0, dmac_pkg::OFS_CONST_HI, 32'h0);
    chk("const_hi", 64'h1, {32'h0, q});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 64'h1_0000_0000, {31'h0, e, q});
    for (int i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      tsel <= 3'(i);
      bsel <= 3'(7 - i);
      ctl <= {i[1] ^ i[3], i[3], 1'b0, i[2], i[1], i[0]};
      ev = expect_of(i);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("result", ev, result);
      chk("psum_out", (i[1] ^ i[3]) ? 64'h0 : ev, psum_out);
      chk("casc_out", i[3] ? 64'h5 : 64'h7FFFD, 64'(casc_out));
    end
    @(posedge pclk);
    ctl[3] <= 1'b1;
    @(posedge pclk);
    ctl[3] <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("acc", ev + ev, result);
    @(negedge pclk);
    chk("acc_off", ev, result);
    @(posedge pclk);
    clr <= 2'h3;
    @(posedge pclk);
    {clr, ena} <= 5'h00;
    @(negedge pclk);
    chk("clr", 64'h0, result);
    chk("clr_casc", 64'h0, 64'(casc_out));
    repeat (3) @(negedge pclk);
    chk("hold", 64'h0, result);
    test_done();
  end
endmodule : dmac_slice_test
`default_nettype wire
